/* File: logic/usb_ep_pkg.sv */
// Purpose: shared constants and types for the endpoint handshake engine
// Assumes: two endpoint pairs, small packet buffers, one clock domain
// Notes: buffer geometry is fixed; the engine state struct lives here too

// ---------------------------------------------------------------------
// constants
// ---------------------------------------------------------------------
package usb_ep_pkg;
    localparam int EPS = 2;
    localparam int EP_W = 1;
    localparam int IDX_W = 3;
    localparam int LEN_W = 4;
    localparam int ADDR_W = 5;
    localparam int BUF_WORDS = 32;
    // bytes held by one endpoint buffer
    localparam logic [LEN_W-1:0] BUF_BYTES = 4'h8;
    localparam logic [LEN_W-1:0] LEN_ONE = 4'h1;
    localparam logic DIR_IN = 1'b0;
    localparam logic DIR_OUT = 1'b1;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // token codes from the packet decoder
    typedef enum logic [1:0] {
        TOK_NONE = 2'h0,
        TOK_IN = 2'h1,
        TOK_OUT = 2'h2,
        TOK_SETUP = 2'h3
    } tok_t;

    // one-hot engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SEND = 3'h2,
        ST_RECV = 3'h4
    } eng_state_t;

    typedef struct packed {
        eng_state_t st;
        logic [EPS-1:0] in_busy;
        logic [EPS-1:0] in_tog;
        logic [EPS-1:0] out_busy;
        logic [EPS-1:0] in_int;
        logic [EPS-1:0] out_int;
        logic [EPS-1:0][LEN_W-1:0] in_len;
        logic [EPS-1:0][LEN_W-1:0] out_len;
        logic [EP_W-1:0] cur_ep;
        logic [LEN_W-1:0] idx;
        logic cur_acc;
        logic cur_quiet;
        logic cur_setup;
        logic setup_lock;
        logic in_pair_sel;
        logic tx_valid;
        logic tx_last;
        logic tx_empty;
        logic tx_tog;
        logic [7:0] tx_data;
        logic hs_valid;
        logic hs_ack;
        logic rst_seen;
        logic [7:0] fw_rdata;
        logic [LEN_W-1:0] fw_len;
        logic [LEN_W-1:0] fw_rd_idx;
    } eng_t;

    localparam eng_t ENG_RST = '{st: ST_IDLE, default: '0};

    // byte address of one buffer location
    function automatic logic [ADDR_W-1:0] buf_addr(input logic dir,
        input logic [EP_W-1:0] ep, input logic [IDX_W-1:0] idx);
        return {dir, ep, idx};
    endfunction
endpackage

/* File: logic/ep_buffer.sv */
// Purpose: packet storage for all IN and OUT endpoint buffers
// Assumes: firmware and engine never write the same byte in one cycle
// Notes: no debug or scan read path exists, only the two ports below

// ---------------------------------------------------------------------
// buffer storage
// ---------------------------------------------------------------------
module ep_buffer
    import usb_ep_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // firmware port
    input wire logic i_fw_we,
    input wire logic [ADDR_W-1:0] i_fw_addr,
    input wire logic [7:0] i_fw_wdata,
    output logic [7:0] o_fw_rdata,
    // engine port
    input wire logic i_eng_we,
    input wire logic [ADDR_W-1:0] i_eng_addr,
    input wire logic [7:0] i_eng_wdata,
    output logic [7:0] o_eng_rdata
);
    typedef struct packed {
        logic [BUF_WORDS-1:0][7:0] mem;
    } buf_t;

    buf_t q;
    buf_t nxt;

    // only the firmware and engine ports reach the bytes
    always_comb
    begin
        nxt = q;
        if (i_fw_we)
        begin
            nxt.mem[i_fw_addr] = i_fw_wdata;
        end
        if (i_eng_we)
        begin
            nxt.mem[i_eng_addr] = i_eng_wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= nxt;
        end
    end

    // combinational reads, the engine registers what it uses
    assign o_fw_rdata = q.mem[i_fw_addr];
    assign o_eng_rdata = q.mem[i_eng_addr];
endmodule

/* File: logic/usb_ep_engine.sv */
// Purpose: endpoint buffer handshake part of the serial engine
// Assumes: token, receive and bus reset inputs come from same-clock logic
// Notes: stale busy, toggle and setup quirks are kept as real silicon does

// ---------------------------------------------------------------------
// engine
// ---------------------------------------------------------------------
module usb_ep_engine
    import usb_ep_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // token and receive stream from the packet decoder
    input wire logic i_tok_valid,
    input wire logic [1:0] i_tok_pid,
    input wire logic [EP_W-1:0] i_tok_ep,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_end,
    input wire logic i_bus_reset,
    // firmware side
    input wire logic [EP_W-1:0] i_fw_ep,
    input wire logic i_fw_wr,
    input wire logic [7:0] i_fw_wdata,
    input wire logic i_fw_arm,
    input wire logic i_fw_rd,
    input wire logic [EPS-1:0] i_fw_in_busy_clr,
    input wire logic [EPS-1:0] i_fw_out_busy_clr,
    input wire logic [EPS-1:0] i_fw_in_int_clr,
    input wire logic [EPS-1:0] i_fw_out_int_clr,
    input wire logic [EPS-1:0] i_fw_in_en,
    input wire logic i_fw_pair_en,
    input wire logic i_fw_reinit,
    // transmit stream and handshake
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_last,
    output logic o_tx_empty,
    output logic o_tx_toggle,
    output logic o_hs_valid,
    output logic o_hs_ack,
    // status to firmware
    output logic [EPS-1:0] o_in_busy,
    output logic [EPS-1:0] o_out_busy,
    output logic [EPS-1:0] o_in_endpoint_interrupt,
    output logic [EPS-1:0] o_out_endpoint_interrupt,
    output logic o_bus_reset_flag,
    output logic [7:0] o_fw_rdata,
    output logic [LEN_W-1:0] o_fw_out_len
);
    eng_t q;
    eng_t nxt;
    logic [7:0] fw_rd_byte;
    logic [7:0] eng_rd_byte;
    logic [ADDR_W-1:0] fw_addr;
    logic [ADDR_W-1:0] eng_addr;
    logic eng_we;

    // buffer addressing; a firmware write beats a read in the same cycle
    assign fw_addr = i_fw_wr ?
        buf_addr(DIR_IN, i_fw_ep, q.in_len[i_fw_ep][IDX_W-1:0]) :
        buf_addr(DIR_OUT, i_fw_ep, q.fw_rd_idx[IDX_W-1:0]);
    assign eng_addr = buf_addr((q.st == ST_RECV), q.cur_ep, q.idx[IDX_W-1:0]);
    assign eng_we = (q.st == ST_RECV) && i_rx_valid && q.cur_acc &&
        (q.idx < BUF_BYTES);

    ep_buffer u_buf (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_fw_we(i_fw_wr && (q.in_len[i_fw_ep] < BUF_BYTES)),
        .i_fw_addr(fw_addr),
        .i_fw_wdata(i_fw_wdata),
        .o_fw_rdata(fw_rd_byte),
        .i_eng_we(eng_we),
        .i_eng_addr(eng_addr),
        .i_eng_wdata(i_rx_data),
        .o_eng_rdata(eng_rd_byte)
    );

    // next state: firmware actions first so hardware sets win over clears, except reinit, which is applied last and wins
    always_comb
    begin
        logic [EP_W-1:0] tgt;
        logic last;
        tgt = '0;
        last = 1'b0;
        nxt = q;
        nxt.tx_valid = 1'b0;
        nxt.tx_last = 1'b0;
        nxt.tx_empty = 1'b0;
        nxt.hs_valid = 1'b0;
        nxt.hs_ack = 1'b0;
        nxt.fw_len = q.out_len[i_fw_ep];
        if (i_bus_reset)
        begin
            nxt.rst_seen = 1'b1;
        end
        if (i_fw_wr && (q.in_len[i_fw_ep] < BUF_BYTES))
        begin
            nxt.in_len[i_fw_ep] = q.in_len[i_fw_ep] + LEN_ONE;
        end
        else if (i_fw_rd)
        begin
            nxt.fw_rdata = fw_rd_byte;
            nxt.fw_rd_idx = q.fw_rd_idx + LEN_ONE;
        end
        if (i_fw_arm)
        begin
            nxt.in_busy[i_fw_ep] = 1'b1;
        end
        for (int e = 0; e < EPS; e++)
        begin
            // busy only drops when firmware says so, never after a send
            if (i_fw_in_busy_clr[e])
            begin
                nxt.in_busy[e] = 1'b0;
                nxt.in_len[e] = '0;
                if (i_fw_pair_en && (EP_W'(e) == q.in_pair_sel))
                begin
                    nxt.in_pair_sel = ~q.in_pair_sel;
                end
            end
            if (i_fw_out_busy_clr[e])
            begin
                nxt.out_busy[e] = 1'b0;
                nxt.fw_rd_idx = '0;
                if (e == 0)
                begin
                    nxt.setup_lock = 1'b0;
                end
            end
            if (!i_fw_in_en[e])
            begin
                nxt.in_tog[e] = 1'b0;
            end
            if (i_fw_in_int_clr[e])
            begin
                nxt.in_int[e] = 1'b0;
            end
            if (i_fw_out_int_clr[e])
            begin
                nxt.out_int[e] = 1'b0;
            end
        end
        case (q.st)
            ST_IDLE:
            begin
                if (i_tok_valid && (i_tok_pid == TOK_IN))
                begin
                    tgt = i_fw_pair_en ? q.in_pair_sel : i_tok_ep;
                    nxt.cur_ep = tgt;
                    nxt.idx = '0;
                    // stale busy resends the held packet
                    if (q.in_busy[tgt] && !i_fw_in_busy_clr[tgt] && i_fw_in_en[tgt])
                    begin
                        nxt.st = ST_SEND;
                    end
                    else
                    begin
                        nxt.hs_valid = 1'b1;
                    end
                end
                else if (i_tok_valid && (i_tok_pid != TOK_NONE))
                begin
                    // pairing fills the lowest free buffer, not the next in turn
                    tgt = i_fw_pair_en ? q.out_busy[0] : i_tok_ep;
                    nxt.cur_ep = tgt;
                    nxt.idx = '0;
                    nxt.st = ST_RECV;
                    nxt.cur_setup = (i_tok_pid == TOK_SETUP);
                    nxt.cur_quiet = (i_tok_pid == TOK_SETUP) && q.setup_lock;
                    nxt.cur_acc = (i_tok_pid == TOK_SETUP) ? !q.setup_lock :
                        !q.out_busy[tgt];
                end
            end
            ST_SEND:
            begin
                last = (q.in_len[q.cur_ep] == '0) ||
                    (q.idx == (q.in_len[q.cur_ep] - LEN_ONE));
                nxt.tx_valid = 1'b1;
                nxt.tx_data = eng_rd_byte;
                nxt.tx_tog = q.in_tog[q.cur_ep];
                nxt.tx_empty = (q.in_len[q.cur_ep] == '0);
                nxt.idx = q.idx + LEN_ONE;
                if (last)
                begin
                    nxt.tx_last = 1'b1;
                    nxt.st = ST_IDLE;
                    nxt.in_tog[q.cur_ep] = ~q.in_tog[q.cur_ep];
                    nxt.in_int[q.cur_ep] = 1'b1;
                end
            end
            ST_RECV:
            begin
                if (i_rx_valid && (q.idx < BUF_BYTES))
                begin
                    nxt.idx = q.idx + LEN_ONE;
                end
                if (i_rx_end)
                begin
                    nxt.st = ST_IDLE;
                    nxt.hs_valid = !q.cur_quiet;
                    nxt.hs_ack = q.cur_acc;
                    if (q.cur_acc)
                    begin
                        nxt.out_busy[q.cur_ep] = 1'b1;
                        nxt.out_len[q.cur_ep] = q.idx;
                        nxt.out_int[q.cur_ep] = 1'b1;
                        nxt.setup_lock = q.setup_lock | q.cur_setup;
                    end
                end
            end
            default:
            begin
                nxt.st = ST_IDLE;
            end
        endcase
        // reinit restores every engine default; buffer bytes are kept
        if (i_fw_reinit)
        begin
            nxt = ENG_RST;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= ENG_RST;
        end
        else
        begin
            q <= nxt;
        end
    end

    // ports straight from the state register
    assign o_tx_valid = q.tx_valid;
    assign o_tx_data = q.tx_data;
    assign o_tx_last = q.tx_last;
    assign o_tx_empty = q.tx_empty;
    assign o_tx_toggle = q.tx_tog;
    assign o_hs_valid = q.hs_valid;
    assign o_hs_ack = q.hs_ack;
    assign o_in_busy = q.in_busy;
    assign o_out_busy = q.out_busy;
    assign o_in_endpoint_interrupt = q.in_int;
    assign o_out_endpoint_interrupt = q.out_int;
    assign o_bus_reset_flag = q.rst_seen;
    assign o_fw_rdata = q.fw_rdata;
    assign o_fw_out_len = q.fw_len;

    // ---------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    logic send_end;
    assign send_end = (q.st == ST_SEND) && (nxt.st == ST_IDLE) && !i_fw_reinit;

    sequence s_tx_start;
        ##2 o_tx_valid ##0 (o_tx_toggle == $past(q.in_tog[q.cur_ep]));
    endsequence
    sequence s_quiet;
        (!o_hs_valid) [*8];
    endsequence

    property p_busy_kept;
        (send_end && !i_fw_in_busy_clr[q.cur_ep]) |=> q.in_busy[$past(q.cur_ep)];
    endproperty
    a_busy_kept: assert property (p_busy_kept) else $error("busy dropped after send");

    property p_resend;
        (q.st == ST_IDLE && i_tok_valid && i_tok_pid == TOK_IN && !i_fw_pair_en &&
            q.in_busy[i_tok_ep] && !i_fw_in_busy_clr[i_tok_ep] &&
            i_fw_in_en[i_tok_ep] && !i_fw_reinit) |-> s_tx_start;
    endproperty
    a_resend: assert property (p_resend) else $error("busy IN token not answered");

    property p_toggle_flip;
        (send_end && i_fw_in_en[q.cur_ep]) |=>
            (q.in_tog[$past(q.cur_ep)] != $past(q.in_tog[q.cur_ep]));
    endproperty
    a_toggle_flip: assert property (p_toggle_flip) else $error("toggle not flipped");

    property p_nak_cleared;
        (q.st == ST_IDLE && i_tok_valid && i_tok_pid == TOK_IN && !i_fw_pair_en &&
            i_fw_in_busy_clr[i_tok_ep] && !i_fw_reinit) |=> (o_hs_valid && !o_hs_ack);
    endproperty
    a_nak_cleared: assert property (p_nak_cleared) else $error("cleared IN not refused");

    property p_setup_quiet;
        (q.st == ST_IDLE && i_tok_valid && i_tok_pid == TOK_SETUP && q.setup_lock &&
            !i_fw_reinit && !i_fw_out_busy_clr[0]) |=> s_quiet;
    endproperty
    a_setup_quiet: assert property (p_setup_quiet) else $error("repeat SETUP answered");

    property p_reinit;
        i_fw_reinit |=> (!q.setup_lock && !o_bus_reset_flag && o_in_busy == '0);
    endproperty
    a_reinit: assert property (p_reinit) else $error("reinit left state");

    property p_bus_reset;
        (i_bus_reset && !i_fw_reinit && !i_fw_arm && i_fw_in_busy_clr == '0) |=>
            (o_bus_reset_flag && o_in_busy == $past(q.in_busy));
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("bus reset touched state");

    property p_tog_disable;
        (!i_fw_in_en[0] && !(send_end && q.cur_ep == '0)) |=> !q.in_tog[0];
    endproperty
    a_tog_disable: assert property (p_tog_disable) else $error("toggle kept when off");

    property p_out_int;
        (q.st == ST_RECV && i_rx_end && q.cur_acc && !i_fw_reinit) |=>
            (o_out_endpoint_interrupt[$past(q.cur_ep)] && o_hs_ack);
    endproperty
    a_out_int: assert property (p_out_int) else $error("no OUT interrupt");
endmodule

/* File: sim/usb_host_model.sv */
// Purpose: host side of the bus, issues tokens, data and bus reset
// Assumes: engine answers within the bounded waits of collect
// Notes: released lines show inverted values, never a held copy

// ---------------------------------------------------------------------
// host model
// ---------------------------------------------------------------------
module usb_host_model
    import usb_ep_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // replies from the engine
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_last,
    input wire logic i_tx_toggle,
    input wire logic i_hs_valid,
    input wire logic i_hs_ack,
    // token, data and reset towards the engine
    output logic o_tok_valid,
    output logic [1:0] o_tok_pid,
    output logic [EP_W-1:0] o_tok_ep,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_end,
    output logic o_bus_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    // reply code: 0 nak, 1 ack, 3 nothing seen, 4 data packet
    int hs;
    logic tog;
    logic [7:0] got[$];
    logic [7:0] sendq[$];

    initial
    begin
        {o_tok_valid, o_tok_pid, o_tok_ep, o_rx_valid, o_rx_end, o_bus_reset} = '0;
        o_rx_data = 8'h5a;
    end

    // one token cycle; pid and ep are inverted once released
    task automatic token(input logic [1:0] pid, input logic [EP_W-1:0] ep);
        @(posedge i_ref_clk);
        o_tok_valid <= 1'b1;
        o_tok_pid <= pid;
        o_tok_ep <= ep;
        @(posedge i_ref_clk);
        o_tok_valid <= 1'b0;
        o_tok_pid <= ~pid;
        o_tok_ep <= ~ep;
    endtask

    // sampled at falling edges so registered outputs are settled
    task automatic collect(input int lim);
        got.delete();
        hs = 3;
        for (int n = 0; n < lim; n++)
        begin
            @(negedge i_ref_clk);
            if (i_hs_valid === 1'b1)
            begin
                hs = (i_hs_ack === 1'b1) ? 1 : 0;
                break;
            end
            if (i_tx_valid === 1'b1)
            begin
                got.push_back(i_tx_data);
                tog = i_tx_toggle;
                hs = 4;
                if (i_tx_last === 1'b1)
                    break;
            end
        end
    endtask

    task automatic in_tok(input logic [EP_W-1:0] ep);
        token(TOK_IN, ep);
        collect(30);
    endtask

    // end marker always a cycle after the last byte
    task automatic out_tok(input logic [1:0] pid, input logic [EP_W-1:0] ep);
        token(pid, ep);
        foreach (sendq[i])
        begin
            o_rx_valid <= 1'b1;
            o_rx_data <= sendq[i];
            @(posedge i_ref_clk);
        end
        o_rx_valid <= 1'b0;
        o_rx_data <= ~o_rx_data;
        o_rx_end <= 1'b1;
        @(posedge i_ref_clk);
        o_rx_end <= 1'b0;
        collect(6);
    endtask

    // host gives up on a silent device and resets the bus
    task automatic bus_reset();
        @(posedge i_ref_clk);
        o_bus_reset <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        o_bus_reset <= 1'b0;
    endtask
endmodule

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the endpoint handshake engine
// Assumes: firmware side driven here, host side by the host model
// Notes: expectations come from queue models kept beside the stimulus

// ---------------------------------------------------------------------
// bench
// ---------------------------------------------------------------------
module tb_top;
    import usb_ep_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [EP_W-1:0] i_fw_ep = '0;
    logic i_fw_wr = 1'b0, i_fw_arm = 1'b0, i_fw_rd = 1'b0, i_fw_pair_en = 1'b0;
    logic i_fw_reinit = 1'b0;
    logic [7:0] i_fw_wdata = 8'h00;
    logic [EPS-1:0] i_fw_in_busy_clr = '0, i_fw_out_busy_clr = '0, i_fw_in_en = '0;
    logic [EPS-1:0] i_fw_in_int_clr = '0, i_fw_out_int_clr = '0;
    wire logic tok_valid, rx_valid, rx_end, bus_rst, tx_valid, tx_last, tx_tog, hs_v, hs_ack;
    wire logic [1:0] tok_pid;
    wire logic [EP_W-1:0] tok_ep;
    wire logic [7:0] rx_data, tx_data, o_fw_rdata;
    wire logic [EPS-1:0] o_in_busy, o_out_busy, o_in_int, o_out_int;
    wire logic o_bus_reset_flag;
    wire logic tx_empty;
    int n_empty = 0;
    wire logic [LEN_W-1:0] o_fw_out_len;
    int seed = 32'h81b78847;
    int n_mismatch = 0;
    int compares = 0;
    // models of armed IN bytes, received OUT bytes and IN toggles
    logic [7:0] mq[EPS][$];
    logic [7:0] oq[EPS][$];
    int mtog[EPS] = '{0, 0};

    always #25 i_ref_clk = ~i_ref_clk;

    usb_ep_engine usb_ep_engine_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_tok_valid(tok_valid), .i_tok_pid(tok_pid), .i_tok_ep(tok_ep),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_end(rx_end), .i_bus_reset(bus_rst),
        .i_fw_ep(i_fw_ep), .i_fw_wr(i_fw_wr), .i_fw_wdata(i_fw_wdata), .i_fw_arm(i_fw_arm),
        .i_fw_rd(i_fw_rd), .i_fw_in_busy_clr(i_fw_in_busy_clr),
        .i_fw_out_busy_clr(i_fw_out_busy_clr), .i_fw_in_int_clr(i_fw_in_int_clr),
        .i_fw_out_int_clr(i_fw_out_int_clr), .i_fw_in_en(i_fw_in_en),
        .i_fw_pair_en(i_fw_pair_en), .i_fw_reinit(i_fw_reinit), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .o_tx_last(tx_last), .o_tx_empty(tx_empty), .o_tx_toggle(tx_tog),
        .o_hs_valid(hs_v), .o_hs_ack(hs_ack), .o_in_busy(o_in_busy), .o_out_busy(o_out_busy),
        .o_in_endpoint_interrupt(o_in_int), .o_out_endpoint_interrupt(o_out_int),
        .o_bus_reset_flag(o_bus_reset_flag), .o_fw_rdata(o_fw_rdata),
        .o_fw_out_len(o_fw_out_len));

    usb_host_model usb_host_model_i (.i_ref_clk(i_ref_clk), .i_tx_valid(tx_valid),
        .i_tx_data(tx_data), .i_tx_last(tx_last), .i_tx_toggle(tx_tog), .i_hs_valid(hs_v),
        .i_hs_ack(hs_ack), .o_tok_valid(tok_valid), .o_tok_pid(tok_pid), .o_tok_ep(tok_ep),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_end(rx_end), .o_bus_reset(bus_rst));

    // zero-length beats counted where registered outputs are settled
    always @(negedge i_ref_clk)
    begin
        if (tx_valid === 1'b1 && tx_empty === 1'b1)
            n_empty++;
    end

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // clear strobes held one cycle, result looked at once they land
    task automatic pulse(input logic [1:0] ib, input logic [1:0] ob, input logic [1:0] ii,
        input logic [1:0] oi);
        @(posedge i_ref_clk);
        {i_fw_in_busy_clr, i_fw_out_busy_clr, i_fw_in_int_clr, i_fw_out_int_clr} <= {ib, ob, ii, oi};
        @(posedge i_ref_clk);
        {i_fw_in_busy_clr, i_fw_out_busy_clr, i_fw_in_int_clr, i_fw_out_int_clr} <= '0;
        @(negedge i_ref_clk);
    endtask

    task automatic load(input int ep, input int n);
        logic [7:0] d;
        mq[ep].delete();
        repeat (n)
        begin
            @(posedge i_ref_clk);
            i_fw_ep <= EP_W'(ep);
            i_fw_wr <= 1'b1;
            d = 8'($random(seed));
            i_fw_wdata <= d;
            mq[ep].push_back(d);
        end
        @(posedge i_ref_clk);
        i_fw_wr <= 1'b0;
        i_fw_wdata <= ~d;
        i_fw_arm <= 1'b1;
        @(posedge i_ref_clk);
        i_fw_arm <= 1'b0;
    endtask

    task automatic in_x(input int ep, input int b, input bit nak);
        usb_host_model_i.in_tok(EP_W'(ep));
        if (usb_host_model_i.hs == 3)
        begin
            $display("[FAIL] in reply expected answer seen none");
            n_mismatch++;
            final_report();
        end
        if (nak)
        begin
            chk("in_nak", 8'h00, 8'(usb_host_model_i.hs));
            return;
        end
        chk("in_len", 8'(mq[b].size()), 8'(usb_host_model_i.got.size()));
        foreach (mq[b][i]) chk("tx_data", mq[b][i], usb_host_model_i.got[i]);
        if (i_fw_pair_en === 1'b0) chk("toggle", 8'(mtog[b]), 8'(usb_host_model_i.tog));
        mtog[b] = 1 - mtog[b];
        chk("in_busy", 8'h01, 8'(o_in_busy[b]));
        chk("in_int", 8'h01, 8'(o_in_int[b]));
    endtask

    task automatic out_x(input logic [1:0] pid, input int ep, input int b, input int n,
        input int e);
        usb_host_model_i.sendq.delete();
        repeat (n) usb_host_model_i.sendq.push_back(8'($random(seed)));
        usb_host_model_i.out_tok(pid, EP_W'(ep));
        chk("hs", 8'(e), 8'(usb_host_model_i.hs));
        if (e == 1)
        begin
            oq[b] = usb_host_model_i.sendq;
            chk("out_busy", 8'h01, 8'(o_out_busy[b]));
            chk("out_int", 8'h01, 8'(o_out_int[b]));
        end
    endtask

    // firmware reads come back one cycle after the strobe
    task automatic rd(input int b);
        @(posedge i_ref_clk);
        i_fw_ep <= EP_W'(b);
        foreach (oq[b][k])
        begin
            @(posedge i_ref_clk);
            i_fw_rd <= 1'b1;
            @(posedge i_ref_clk);
            i_fw_rd <= 1'b0;
            @(negedge i_ref_clk);
            chk("fw_rdata", oq[b][k], o_fw_rdata);
        end
        chk("out_len", 8'(oq[b].size()), 8'(o_fw_out_len));
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk("rst_out", 8'h00, {o_in_busy, o_out_busy, o_in_int, tx_valid, o_bus_reset_flag});
        @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        i_fw_in_en <= 2'b11;
        load(0, 3);
        in_x(0, 0, 0);
        in_x(0, 0, 0);
        pulse(2'b01, 2'b00, 2'b01, 2'b00);
        chk("busy_clr", 8'h00, 8'(o_in_busy[0]));
        in_x(0, 0, 1);
        $display("test in_resend done");
        load(0, 2);
        in_x(0, 0, 0);
        pulse(2'b01, 2'b00, 2'b01, 2'b00);
        @(posedge i_ref_clk);
        i_fw_in_en <= 2'b10;
        in_x(0, 0, 1);
        @(posedge i_ref_clk);
        i_fw_in_en <= 2'b11;
        mtog[0] = 0;
        load(0, 1);
        in_x(0, 0, 0);
        pulse(2'b01, 2'b00, 2'b01, 2'b00);
        // armed with nothing written: one empty beat, toggle still flips
        load(0, 0);
        usb_host_model_i.in_tok(EP_W'(0));
        @(posedge i_ref_clk);
        chk("tx_empty", 8'h01, 8'(n_empty));
        chk("toggle", 8'(mtog[0]), 8'(usb_host_model_i.tog));
        mtog[0] = 1 - mtog[0];
        pulse(2'b01, 2'b00, 2'b01, 2'b00);
        $display("test toggle_reset done");
        out_x(TOK_OUT, 1, 1, 1 + ($unsigned($random(seed)) % 8), 1);
        out_x(TOK_OUT, 1, 1, 3, 0);
        rd(1);
        pulse(2'b00, 2'b10, 2'b00, 2'b10);
        chk("out_clr", 8'h00, 8'(o_out_busy[1]));
        $display("test out_busy done");
        out_x(TOK_SETUP, 0, 0, 8, 1);
        out_x(TOK_SETUP, 0, 0, 8, 3);
        usb_host_model_i.bus_reset();
        @(negedge i_ref_clk);
        chk("reset_flag", 8'h01, 8'(o_bus_reset_flag));
        out_x(TOK_SETUP, 0, 0, 8, 3);
        @(posedge i_ref_clk);
        i_fw_reinit <= 1'b1;
        @(posedge i_ref_clk);
        i_fw_reinit <= 1'b0;
        mtog = '{0, 0};
        out_x(TOK_SETUP, 0, 0, 8, 1);
        chk("flag_clr", 8'h00, 8'(o_bus_reset_flag));
        rd(0);
        pulse(2'b00, 2'b01, 2'b00, 2'b01);
        $display("test setup_retry done");
        @(posedge i_ref_clk);
        i_fw_pair_en <= 1'b1;
        out_x(TOK_OUT, 1, 0, 4, 1);
        out_x(TOK_OUT, 0, 1, 5, 1);
        rd(0);
        pulse(2'b00, 2'b01, 2'b00, 2'b01);
        rd(1);
        pulse(2'b00, 2'b11, 2'b00, 2'b11);
        load(0, 2);
        load(1, 2);
        in_x(1, 0, 0);
        in_x(1, 0, 0);
        pulse(2'b01, 2'b00, 2'b01, 2'b00);
        in_x(0, 1, 0);
        $display("test pairing done");
        final_report();
    end
endmodule
